// *** inc/sdmd_consts.svh ***
// Constants for the step/direction microstep driver input logic
// Summary of operation
// - Each rising pulse edge while the drive is on moves position one microstep at selected resolution.
// - Standard variant: select 0 gives half step, 1 gives eighth step.
// - Low-noise variant: select 0 gives eighth step, 1 gives 1/256 step.
// - Direction low steps clockwise, high steps counter-clockwise.
// - Resolution select is latched only while disabled and current off.
// - Over-temperature switches drive off and latches a thermal fault.
// - Supply out of range switches drive off and latches supply fault.
// - After a fault, only an enable rising edge after clearing re-energizes.
// - Fault clears only after temperature or supply passes its hysteresis.
// - At standstill without boost the current setpoint drops to two thirds of nominal.
`ifndef SDMD_CONSTS_SVH
`define SDMD_CONSTS_SVH
`define SDMD_ADDR_CTRL 12'h000
`define SDMD_ADDR_STAT 12'h004
`define SDMD_ADDR_IRQ_STAT 12'h008
`define SDMD_ADDR_IRQ_EN 12'h00C
`define SDMD_ADDR_IRQ_CLR 12'h010
`define SDMD_ADDR_POS 12'h014
`define SDMD_ADDR_IDLE 12'h018
`define SDMD_ADDR_ISET 12'h01C
`define SDMD_CTRL_LOWNOISE 0
`define SDMD_IRQ_THERM 0
`define SDMD_IRQ_SUPPLY 1
`define SDMD_IRQ_STILL 2
`define SDMD_STEP_HALF 16'h0080
`define SDMD_STEP_EIGHTH 16'h0020
`define SDMD_STEP_FINE 16'h0001
`define SDMD_T_IDLE_MS 10
`define SDMD_CLK_MHZ 100
`define SDMD_IDLE_CYC (`SDMD_T_IDLE_MS * `SDMD_CLK_MHZ * 1000)
`define SDMD_T_HYST_C 10
`define SDMD_HYST_MV 1000
`define SDMD_ISET_NOM 8'hC0
`define SDMD_ISET_BOOST 8'hFF
`endif

// *** inc/sdmd_pkg.sv ***
// Types for the step/direction microstep driver input logic
package sdmd_pkg;
	typedef struct packed {
		logic pulse;
		logic dir;
		logic res_sel;
		logic enable;
		logic boost;
	} sdmd_ctl_t;
	typedef struct packed {
		logic over_temp;
		logic temp_ok;
		logic supply_bad;
		logic supply_ok;
	} sdmd_sense_t;
	typedef enum logic [1:0] {
		SDMD_OFF,
		SDMD_ON,
		SDMD_FAULT
	} sdmd_state_t;
endpackage : sdmd_pkg

// *** core/sdmd_top.sv ***
// Step/direction microstep driver input logic with APB registers
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sdmd_consts.svh"
module sdmd_top #(
	parameter logic [31:0] IDLE_CYC = 32'(`SDMD_IDLE_CYC)
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire sdmd_pkg::sdmd_ctl_t ctl,
	input wire sdmd_pkg::sdmd_sense_t sense,
	output logic drive_on,
	output logic [7:0] current_set,
	output logic [15:0] position,
	output logic irq
);
	import sdmd_pkg::*;
	sdmd_state_t state, next_state;
	logic pulse_d, next_pulse_d, en_d, next_en_d;
	logic res_lat, next_res_lat, low_noise, next_low_noise;
	logic therm_flt, next_therm_flt, sup_flt, next_sup_flt;
	logic still, next_still;
	logic [31:0] idle_cnt, next_idle_cnt, idle_lim, next_idle_lim;
	logic [15:0] next_position;
	logic [7:0] iset_nom, next_iset_nom, next_current_set;
	logic [2:0] ist, next_ist, ien, next_ien;
	logic [31:0] next_prdata;
	logic pulse_rise, en_rise, wr, rd, fault_any, unmapped;
	logic [15:0] inc;
	logic [2:0] ev;
	assign wr = psel & penable & pwrite;
	assign rd = psel & penable & ~pwrite;
	assign pready = 1'b1;
	assign pulse_rise = ctl.pulse & ~pulse_d;
	assign en_rise = ctl.enable & ~en_d;
	assign fault_any = therm_flt | sup_flt;
	assign irq = |(ist & ien);
	always_comb begin
		unmapped = 1'b0;
		next_prdata = 32'h0;
		if (paddr == `SDMD_ADDR_CTRL) begin
			next_prdata = {31'h0, low_noise};
		end else if (paddr == `SDMD_ADDR_STAT) begin
			next_prdata = {26'h0, still, sup_flt, therm_flt, res_lat,
				state == SDMD_ON, ctl.dir};
		end else if (paddr == `SDMD_ADDR_IRQ_STAT) begin
			next_prdata = {29'h0, ist};
		end else if (paddr == `SDMD_ADDR_IRQ_EN) begin
			next_prdata = {29'h0, ien};
		end else if (paddr == `SDMD_ADDR_IRQ_CLR) begin
			next_prdata = 32'h0;
		end else if (paddr == `SDMD_ADDR_POS) begin
			next_prdata = {16'h0, position};
		end else if (paddr == `SDMD_ADDR_IDLE) begin
			next_prdata = idle_lim;
		end else if (paddr == `SDMD_ADDR_ISET) begin
			next_prdata = {24'h0, iset_nom};
		end else begin
			unmapped = 1'b1;
		end
	end
	assign pslverr = psel & penable & unmapped;
	always_comb begin
		next_state = state;
		next_pulse_d = ctl.pulse;
		next_en_d = ctl.enable;
		next_therm_flt = therm_flt;
		next_sup_flt = sup_flt;
		next_res_lat = res_lat;
		next_low_noise = low_noise;
		next_idle_lim = idle_lim;
		next_iset_nom = iset_nom;
		next_ien = ien;
		next_position = position;
		next_idle_cnt = idle_cnt;
		next_still = still;
		ev = 3'h0;
		if (sense.over_temp) begin
			next_therm_flt = 1'b1;
		end else if (sense.temp_ok) begin
			next_therm_flt = 1'b0;
		end
		if (sense.supply_bad) begin
			next_sup_flt = 1'b1;
		end else if (sense.supply_ok) begin
			next_sup_flt = 1'b0;
		end
		ev[`SDMD_IRQ_THERM] = sense.over_temp & ~therm_flt;
		ev[`SDMD_IRQ_SUPPLY] = sense.supply_bad & ~sup_flt;
		case (state)
			SDMD_OFF: begin
				if (!ctl.enable) begin
					next_res_lat = ctl.res_sel;
				end
				if (fault_any || sense.over_temp || sense.supply_bad) begin
					next_state = SDMD_FAULT;
				end else if (ctl.enable) begin
					next_state = SDMD_ON;
				end
			end
			SDMD_ON: begin
				if (sense.over_temp || sense.supply_bad) begin
					next_state = SDMD_FAULT;
				end else if (!ctl.enable) begin
					next_state = SDMD_OFF;
				end
			end
			default: begin
				if (!ctl.enable) begin
					next_res_lat = ctl.res_sel;
				end
				if (!fault_any && en_rise && !sense.over_temp &&
					!sense.supply_bad) begin
					next_state = SDMD_ON;
				end
			end
		endcase
		if (low_noise) begin
			inc = res_lat ? `SDMD_STEP_FINE : `SDMD_STEP_EIGHTH;
		end else begin
			inc = res_lat ? `SDMD_STEP_EIGHTH : `SDMD_STEP_HALF;
		end
		if (pulse_rise && state == SDMD_ON) begin
			if (ctl.dir) begin
				next_position = position - inc;
			end else begin
				next_position = position + inc;
			end
		end
		if (pulse_rise) begin
			next_idle_cnt = 32'h0;
			next_still = 1'b0;
		end else if (idle_cnt >= idle_lim) begin
			ev[`SDMD_IRQ_STILL] = ~still;
			next_still = 1'b1;
		end else begin
			next_idle_cnt = idle_cnt + 32'h1;
		end
		if (wr && paddr == `SDMD_ADDR_CTRL && state != SDMD_ON) begin
			next_low_noise = pwdata[`SDMD_CTRL_LOWNOISE];
		end
		if (wr && paddr == `SDMD_ADDR_IRQ_EN) begin
			next_ien = pwdata[2:0];
		end
		if (wr && paddr == `SDMD_ADDR_IDLE) begin
			next_idle_lim = pwdata;
		end
		if (wr && paddr == `SDMD_ADDR_ISET) begin
			next_iset_nom = pwdata[7:0];
		end
		next_ist = ist;
		if (wr && paddr == `SDMD_ADDR_IRQ_CLR) begin
			next_ist = ist & ~pwdata[2:0];
		end
		next_ist = next_ist | ev;
		if (next_state != SDMD_ON) begin
			next_current_set = 8'h00;
		end else if (ctl.boost) begin
			next_current_set = `SDMD_ISET_BOOST;
		end else if (next_still) begin
			next_current_set = 8'((16'(iset_nom) * 16'h2) / 16'h3);
		end else begin
			next_current_set = iset_nom;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SDMD_OFF;
			pulse_d <= 1'b0;
			en_d <= 1'b0;
			therm_flt <= 1'b0;
			sup_flt <= 1'b0;
			res_lat <= 1'b0;
			low_noise <= 1'b0;
			idle_lim <= 32'(`SDMD_IDLE_CYC);
			iset_nom <= `SDMD_ISET_NOM;
			ien <= 3'h0;
			ist <= 3'h0;
			position <= 16'h0;
			idle_cnt <= 32'h0;
			still <= 1'b0;
			current_set <= 8'h00;
			drive_on <= 1'b0;
			prdata <= 32'h0;
		end else begin
			state <= next_state;
			pulse_d <= next_pulse_d;
			en_d <= next_en_d;
			therm_flt <= next_therm_flt;
			sup_flt <= next_sup_flt;
			res_lat <= next_res_lat;
			low_noise <= next_low_noise;
			idle_lim <= (idle_lim == 32'h0 && !wr) ? IDLE_CYC : next_idle_lim;
			iset_nom <= next_iset_nom;
			ien <= next_ien;
			ist <= next_ist;
			position <= next_position;
			idle_cnt <= next_idle_cnt;
			still <= next_still;
			current_set <= next_current_set;
			drive_on <= (next_state == SDMD_ON);
			// Latch in setup so data stands at the zero-wait access edge
			prdata <= (psel & ~penable & ~pwrite) ? next_prdata : prdata;
		end
	end
endmodule : sdmd_top

// *** sim/sdmd_chk.sv ***
// Port checker for the driver input logic
`timescale 1ns/1ps
module sdmd_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire sdmd_pkg::sdmd_ctl_t ctl,
	input wire sdmd_pkg::sdmd_sense_t sense,
	input wire logic drive_on,
	input wire logic [15:0] position
);
	import sdmd_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_high: assert property (pready) else $error("pready low");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h01C
		|-> pslverr) else $error("no error on unmapped access");
	a_temp_cut: assert property (sense.over_temp |=> !drive_on)
		else $error("drive stays on over temperature");
	a_supply_cut: assert property (sense.supply_bad |=> !drive_on)
		else $error("drive stays on with bad supply");
	a_disable_off: assert property (!ctl.enable [*2] |-> !drive_on)
		else $error("drive on while disabled");
	a_rearm_edge: assert property ($rose(drive_on) |-> $past(ctl.enable))
		else $error("drive started without enable");
	a_pos_idle: assert property (!drive_on [*3] |-> $stable(position))
		else $error("position moved while off");
	a_step_cause: assert property ($changed(position)
		|-> $past(ctl.pulse) || $past(ctl.pulse, 2))
		else $error("position moved without pulse");
endmodule : sdmd_chk
bind sdmd_top sdmd_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
	.pready, .pslverr, .ctl, .sense, .drive_on, .position);

// *** sim/sdmd_mc.sv ***
// Motion controller model: step pulses and direction
`timescale 1ns/1ps
module sdmd_mc (
	input wire logic pclk,
	output logic pulse,
	output logic dir
);
	initial begin
		pulse = 1'b0;
		dir = 1'b0;
	end
	// Pulses stay 250 cycles high and at least 250 low: 200 kHz at most
	task automatic steps(input int n, input logic d, input int low);
		dir <= d;
		repeat (250) @(posedge pclk);
		for (int i = 0; i < n; i++) begin
			pulse <= 1'b1;
			repeat (250) @(posedge pclk);
			pulse <= 1'b0;
			repeat (low) @(posedge pclk);
		end
	endtask : steps
endmodule : sdmd_mc

// *** sim/sdmd_tb.sv ***
// Self-checking testbench for the driver input logic
`timescale 1ns/1ps
module sdmd_tb;
	import sdmd_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd, r;
	logic pready, pslverr, err, drive_on, irq, pulse, dir;
	logic sel = 1'b0;
	logic en = 1'b0;
	logic boost = 1'b0;
	logic [7:0] current_set;
	logic [15:0] position;
	logic [15:0] pos = 16'h0;
	logic [31:0] seed = 32'h15;
	sdmd_ctl_t ctl;
	sdmd_sense_t sense = 4'h5;
	int fail_count = 0;
	int comparisons = 0;
	int n, st;
	assign ctl = {pulse, dir, sel, en, boost};
	always #5 pclk = ~pclk;
	sdmd_mc mc (.pclk, .pulse, .dir);
	sdmd_top #(.IDLE_CYC(32'h32)) dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctl, .sense,
		.drive_on, .current_set, .position, .irq);
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", s, e, g);
			fail_count++;
		end
	endtask : chk
	task automatic summarize();
		if (fail_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	initial begin
		repeat (40000) @(posedge pclk);
		fail_count++;
		summarize();
	end
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, 12'h018, 32'h3E8);
		for (int i = 0; i < 4; i++) begin
			r = xs();
			en <= 1'b0;
			repeat (3) @(posedge pclk);
			apb(1'b1, 12'h000, {31'h0, i[1]});
			sel <= i[0];
			boost <= r[1];
			repeat (3) @(posedge pclk);
			en <= 1'b1;
			repeat (3) @(posedge pclk);
			sel <= ~i[0];
			n = r[5:4] + 1;
			mc.steps(n, r[3], 250);
			st = i[1] ? (i[0] ? 1 : 32) : (i[0] ? 32 : 128);
			pos = r[3] ? pos - n * st : pos + n * st;
			chk("position", pos, position);
			chk("current", r[1] ? 8'hFF : 8'hC0, current_set);
			boost <= 1'b0;
			repeat (1100) @(posedge pclk);
			chk("still", 8'h80, current_set);
		end
		apb(1'b1, 12'h00C, 32'h1);
		for (int k = 0; k < 2; k++) begin
			sense <= k ? 4'h6 : 4'h9;
			repeat (2) @(posedge pclk);
			sense <= 4'h5;
			repeat (5) @(posedge pclk);
			chk("fault_off", 1'b0, drive_on);
			chk("irq", k == 0, irq);
			apb(1'b0, 12'h008, 32'h0);
			apb(1'b0, 12'h008, 32'h0);
			chk("fault_flag", 1'b1, rd[k]);
			apb(1'b1, 12'h010, 32'h7);
			repeat (2) @(posedge pclk);
			chk("irq_clear", 1'b0, irq);
			en <= 1'b0;
			repeat (3) @(posedge pclk);
			en <= 1'b1;
			repeat (3) @(posedge pclk);
			chk("rearm", 1'b1, drive_on);
		end
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped", 1'b1, err);
		summarize();
	end
endmodule : sdmd_tb
